//--- hdl/efc_consts.svh
// Constants for the embedded flash controller
`ifndef EFC_CONSTS_SVH
`define EFC_CONSTS_SVH
`define EFC_BANK_AW 12
`define EFC_WL_BYTES 32
`define EFC_WL_IDX_W 7
`define EFC_WL_PER_BANK 8'd128
`define EFC_WL_BITS 256
`define EFC_CODE_W 12
`define EFC_WL_CODE_W 384
`define EFC_CORE_CLOCK_DIV 3
`define EFC_RD_CORE_CLOCK 3
`define EFC_PROG_CYC 209440
`define EFC_ERASE_CYC 8175360
`define EFC_NSECT 10
`define EFC_P_NSECT 3
`define EFC_P_SECT_LIMS '{8'd120, 8'd124, 8'd128}
`define EFC_D_SECT_LIMS '{8'd32, 8'd64, 8'd80, 8'd96, 8'd104, 8'd112, 8'd116, 8'd120, 8'd124, 8'd128}
`endif

//--- hdl/efc_pkg.sv
// Types and check-code helpers for the embedded flash controller
`include "efc_consts.svh"
package efc_pkg;
    typedef enum logic {EFC_OP_PROG, EFC_OP_ERASE} efc_op_t;
    typedef enum logic [1:0] {EFC_OS_IDLE, EFC_OS_PROG, EFC_OS_ERASE} efc_op_st_t;
    typedef enum logic {EFC_RS_IDLE, EFC_RS_WAIT} efc_rd_st_t;
    typedef logic [`EFC_CODE_W:1] efc_code_t;

    // Single-error-correcting code; all-zero data gives an all-zero code, so erased reads 0
    function automatic efc_code_t efc_enc(input logic [7:0] d);
        efc_code_t c;
        int j;
        c = '0;
        j = 0;
        for (int p = 1; p <= `EFC_CODE_W; p++)
            if ((p & (p - 1)) != 0)
            begin
                c[p] = d[j];
                j++;
            end
        for (int k = 0; k < 4; k++)
            for (int p = 1; p <= `EFC_CODE_W; p++)
                if (((p & (p - 1)) != 0) && p[k])
                    c[1 << k] ^= c[p];
        return c;
    endfunction

    function automatic logic [7:0] efc_data(input efc_code_t c);
        logic [7:0] d;
        int j;
        d = '0;
        j = 0;
        for (int p = 1; p <= `EFC_CODE_W; p++)
            if ((p & (p - 1)) != 0)
            begin
                d[j] = c[p];
                j++;
            end
        return d;
    endfunction
endpackage

//--- hdl/efc_arr_if.sv
// Port bundle between the controller and one flash bank array
`timescale 1ns/1ps
`include "efc_consts.svh"
interface efc_arr_if;
    logic [`EFC_BANK_AW-1:0] rd_addr;
    logic [`EFC_CODE_W:1] rd_code;
    logic wr_en;
    logic [`EFC_WL_IDX_W-1:0] wr_wl;
    logic [`EFC_WL_CODE_W-1:0] wr_code;
    logic [`EFC_WL_CODE_W-1:0] wl_code;
    modport ctl (output rd_addr, wr_en, wr_wl, wr_code, input rd_code, wl_code);
    modport mem (input rd_addr, wr_en, wr_wl, wr_code, output rd_code, wl_code);
endinterface

//--- hdl/efc_ecc.sv
// Check-code decoder with single-bit correction
`timescale 1ns/1ps
`include "efc_consts.svh"
module efc_ecc
    import efc_pkg::*;
(
    input wire efc_pkg::efc_code_t code_in,
    output logic [7:0] data_out,
    output logic corrected
);
    logic [3:0] synd;
    efc_code_t fixed;

    always_comb
    begin
        synd = '0;
        for (int p = 1; p <= `EFC_CODE_W; p++)
            if (code_in[p])
                synd ^= 4'(p);
        fixed = code_in;
        corrected = (synd != '0) && (synd <= 4'(`EFC_CODE_W));
        if (corrected)
            fixed[synd] = ~code_in[synd];
        data_out = efc_data(fixed);
    end
endmodule

//--- hdl/efc_bank.sv
// One 4-Kbyte flash bank stored as wordlines of coded bytes
`timescale 1ns/1ps
`include "efc_consts.svh"
module efc_bank
    import efc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    efc_arr_if.mem mp
);
    localparam int NWL = 1 << `EFC_WL_IDX_W;
    logic [`EFC_WL_CODE_W-1:0] mem_r [NWL];
    logic [8:0] bit_off;

    assign bit_off = 9'(mp.rd_addr[4:0]) * 9'(`EFC_CODE_W);
    assign mp.rd_code = mem_r[mp.rd_addr[`EFC_BANK_AW-1:5]][bit_off +: `EFC_CODE_W];
    assign mp.wl_code = mem_r[mp.wr_wl];

    // Reset stands in for the erased state at delivery
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NWL; i++)
                mem_r[i] <= '0;
        end
        else if (mp.wr_en)
        begin
            mem_r[mp.wr_wl] <= mp.wr_code;
        end
    end
endmodule

//--- hdl/efc_top.sv
// Embedded flash controller: coded byte reads, background program and erase
`timescale 1ns/1ps
`include "efc_consts.svh"
module efc_top
    import efc_pkg::*;
#(
    parameter int NB = 4,
    parameter int DATA_BANK = NB - 1,
    parameter int PROG_CYC = `EFC_PROG_CYC,
    parameter int ERASE_CYC = `EFC_ERASE_CYC,
    localparam int BW = (NB > 1) ? $clog2(NB) : 1,
    localparam int AW = `EFC_BANK_AW + BW
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic rd_req,
    input wire logic [AW-1:0] rd_addr,
    output logic rd_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic rd_corrected,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire efc_pkg::efc_op_t cmd_op,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [`EFC_NSECT-1:0] cmd_sect_mask,
    input wire logic [`EFC_WL_BITS-1:0] cmd_wl_data,
    input wire logic erase_abort,
    output logic [NB-1:0] bank_busy,
    output logic op_done,
    output logic op_aborted
);
    import efc_pkg::*;

    // Read latency in system clocks: three core clock periods of three system clocks
    localparam int RD_CYC = `EFC_RD_CORE_CLOCK * `EFC_CORE_CLOCK_DIV;

    efc_op_st_t op_st_r, op_st_nxt;
    logic [BW-1:0] op_bank_r, op_bank_nxt;
    logic [`EFC_WL_IDX_W-1:0] op_wl_r, op_wl_nxt;
    logic [`EFC_NSECT-1:0] op_mask_r, op_mask_nxt;
    logic [`EFC_WL_BITS-1:0] op_buf_r, op_buf_nxt;
    logic [31:0] op_cnt_r, op_cnt_nxt;
    logic [7:0] sweep_r, sweep_nxt;
    efc_rd_st_t rd_st_r, rd_st_nxt;
    logic [AW-1:0] rd_addr_r, rd_addr_nxt;
    logic [3:0] rd_cnt_r, rd_cnt_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_corr_r, rd_corr_nxt;
    logic wr_any, erase_hit, abort_now;
    logic [`EFC_WL_IDX_W-1:0] wr_wl;
    logic [`EFC_WL_CODE_W-1:0] wr_code, prog_code;
    logic [`EFC_CODE_W:1] rd_codes [NB];
    logic [`EFC_WL_CODE_W-1:0] wl_codes [NB];
    logic [`EFC_CODE_W:1] sel_code;
    logic [7:0] dec_data;
    logic dec_corr;

    // Sector of a wordline; the data bank is cut finer than program banks
    function automatic logic [3:0] efc_sector(input logic is_data,
                                              input logic [`EFC_WL_IDX_W-1:0] wl);
        logic [7:0] plim [`EFC_P_NSECT];
        logic [7:0] dlim [`EFC_NSECT];
        logic [3:0] s;
        plim = `EFC_P_SECT_LIMS;
        dlim = `EFC_D_SECT_LIMS;
        s = '0;
        for (int i = `EFC_NSECT - 1; i >= 0; i--)
            if (is_data ? ({1'b0, wl} < dlim[i]) : (i < `EFC_P_NSECT && {1'b0, wl} < plim[i]))
                s = 4'(i);
        return s;
    endfunction

    // One array per bank; the last bank by default is the data bank
    for (genvar g = 0; g < NB; g++)
    begin : g_bank
        efc_arr_if arr();
        efc_bank u_bank (.core_clk(core_clk), .rst_b(rst_b), .mp(arr.mem));
        assign arr.rd_addr = rd_addr_r[`EFC_BANK_AW-1:0];
        assign arr.wr_en = wr_any && (op_bank_r == BW'(g));
        assign arr.wr_wl = wr_wl;
        assign arr.wr_code = wr_code;
        assign rd_codes[g] = arr.rd_code;
        assign wl_codes[g] = arr.wl_code;
        assign bank_busy[g] = (op_st_r != EFC_OS_IDLE) && (op_bank_r == BW'(g));
    end

    // Programming only adds ones, so zeros in a second pass keep older bytes
    for (genvar b = 0; b < `EFC_WL_BYTES; b++)
    begin : g_enc
        assign prog_code[b*`EFC_CODE_W +: `EFC_CODE_W] = efc_enc(op_buf_r[b*8 +: 8]
            | efc_data(wl_codes[op_bank_r][b*`EFC_CODE_W +: `EFC_CODE_W]));
    end

    assign sel_code = rd_codes[rd_addr_r[AW-1:`EFC_BANK_AW]];
    efc_ecc u_ecc (.code_in(sel_code), .data_out(dec_data), .corrected(dec_corr));

    // Operation engine
    assign op_done = (op_st_r != EFC_OS_IDLE) && (op_cnt_r == '0);
    assign abort_now = (op_st_r == EFC_OS_ERASE) && erase_abort && !op_done;
    assign op_aborted = abort_now;
    assign cmd_ready = (op_st_r == EFC_OS_IDLE) && (rd_st_r == EFC_RS_IDLE);
    assign erase_hit = op_mask_r[efc_sector(op_bank_r == BW'(DATA_BANK),
                                            sweep_r[`EFC_WL_IDX_W-1:0])];

    always_comb
    begin
        op_st_nxt = op_st_r;
        op_bank_nxt = op_bank_r;
        op_wl_nxt = op_wl_r;
        op_mask_nxt = op_mask_r;
        op_buf_nxt = op_buf_r;
        op_cnt_nxt = op_cnt_r;
        sweep_nxt = sweep_r;
        wr_any = 1'b0;
        wr_wl = op_wl_r;
        wr_code = prog_code;
        unique case (op_st_r)
            EFC_OS_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_bank_nxt = cmd_addr[AW-1:`EFC_BANK_AW];
                    op_wl_nxt = cmd_addr[`EFC_BANK_AW-1:5];
                    op_mask_nxt = cmd_sect_mask;
                    op_buf_nxt = cmd_wl_data;
                    sweep_nxt = '0;
                    if (cmd_op == EFC_OP_PROG)
                    begin
                        op_st_nxt = EFC_OS_PROG;
                        op_cnt_nxt = 32'(PROG_CYC - 1);
                    end
                    else
                    begin
                        op_st_nxt = EFC_OS_ERASE;
                        op_cnt_nxt = 32'(ERASE_CYC - 1);
                    end
                    if (!cmd_ready)
                        op_st_nxt = EFC_OS_IDLE;
                end
            end
            EFC_OS_PROG:
            begin
                // Whole wordline is committed once, at the end of the program time
                if (op_done)
                begin
                    wr_any = 1'b1;
                    op_st_nxt = EFC_OS_IDLE;
                end
                else
                    op_cnt_nxt = op_cnt_r - 32'd1;
            end
            EFC_OS_ERASE:
            begin
                // Sweep clears selected sectors early; an abort before the 128-wordline sweep ends leaves a partial erase
                wr_wl = sweep_r[`EFC_WL_IDX_W-1:0];
                wr_code = '0;
                if (sweep_r < `EFC_WL_PER_BANK && !abort_now)
                begin
                    wr_any = erase_hit;
                    sweep_nxt = sweep_r + 8'd1;
                end
                if (op_done || abort_now)
                    op_st_nxt = EFC_OS_IDLE;
                else
                    op_cnt_nxt = op_cnt_r - 32'd1;
            end
            default:
                op_st_nxt = EFC_OS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_st_r <= EFC_OS_IDLE;
            op_bank_r <= '0;
            op_wl_r <= '0;
            op_mask_r <= '0;
            op_buf_r <= '0;
            op_cnt_r <= '0;
            sweep_r <= '0;
        end
        else
        begin
            op_st_r <= op_st_nxt;
            op_bank_r <= op_bank_nxt;
            op_wl_r <= op_wl_nxt;
            op_mask_r <= op_mask_nxt;
            op_buf_r <= op_buf_nxt;
            op_cnt_r <= op_cnt_nxt;
            sweep_r <= sweep_nxt;
        end
    end

    // Read path runs beside a background operation
    assign rd_ready = (rd_st_r == EFC_RS_IDLE)
                      && !bank_busy[rd_addr[AW-1:`EFC_BANK_AW]];
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign rd_corrected = rd_corr_r;

    always_comb
    begin
        rd_st_nxt = rd_st_r;
        rd_addr_nxt = rd_addr_r;
        rd_cnt_nxt = rd_cnt_r;
        rd_valid_nxt = 1'b0;
        rd_data_nxt = rd_data_r;
        rd_corr_nxt = rd_corr_r;
        unique case (rd_st_r)
            EFC_RS_IDLE:
            begin
                if (rd_req && rd_ready)
                begin
                    rd_st_nxt = EFC_RS_WAIT;
                    rd_addr_nxt = rd_addr;
                    rd_cnt_nxt = 4'(RD_CYC - 2);
                end
            end
            EFC_RS_WAIT:
            begin
                if (rd_cnt_r == '0)
                begin
                    rd_st_nxt = EFC_RS_IDLE;
                    rd_valid_nxt = 1'b1;
                    rd_data_nxt = dec_data;
                    rd_corr_nxt = dec_corr;
                end
                else
                    rd_cnt_nxt = rd_cnt_r - 4'd1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_st_r <= EFC_RS_IDLE;
            rd_addr_r <= '0;
            rd_cnt_r <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
            rd_corr_r <= 1'b0;
        end
        else
        begin
            rd_st_r <= rd_st_nxt;
            rd_addr_r <= rd_addr_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
            rd_corr_r <= rd_corr_nxt;
        end
    end

    // Checking helpers
    logic [31:0] elapsed_r;
    efc_op_st_t kind_r;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            elapsed_r <= '0;
            kind_r <= EFC_OS_IDLE;
        end
        else
        begin
            elapsed_r <= (cmd_valid && cmd_ready) ? 32'd1 : elapsed_r + 32'd1;
            kind_r <= op_st_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_read_latency: assert property (rd_req && rd_ready |-> ##1 !rd_valid[*8] ##1 rd_valid)
        else $error("read data not returned after nine clocks");
    a_ecc_fix: assert property (rd_valid && rd_corrected |-> $past(sel_code) != efc_enc(rd_data))
        else $error("correction flagged on a clean code");
    a_ecc_clean: assert property (rd_valid && !rd_corrected |-> $past(sel_code) == efc_enc(rd_data))
        else $error("read data not matching stored code");
    a_prog_time: assert property (op_done && op_st_r == EFC_OS_PROG |-> elapsed_r == 32'(PROG_CYC))
        else $error("program time wrong");
    a_erase_time: assert property (op_done && op_st_r == EFC_OS_ERASE |-> elapsed_r == 32'(ERASE_CYC))
        else $error("erase time wrong");
    a_abort_stop: assert property (abort_now |-> ##1 (bank_busy == '0) && !op_done)
        else $error("erase kept running after abort");
    a_busy_stall: assert property (rd_req && bank_busy[rd_addr[AW-1:`EFC_BANK_AW]] |-> !rd_ready)
        else $error("read to busy bank accepted");
    a_bg_read: assert property (rd_req && rd_st_r == EFC_RS_IDLE && (bank_busy == '0 || !bank_busy[rd_addr[AW-1:`EFC_BANK_AW]]) |-> rd_ready)
        else $error("read to idle bank refused");
    a_erase_scope: assert property (wr_any && op_st_r == EFC_OS_ERASE |-> erase_hit && wr_code == '0)
        else $error("erase touched an unselected sector");
    a_prog_once: assert property (wr_any && op_st_r == EFC_OS_PROG |-> op_done ##1 bank_busy == '0)
        else $error("wordline written outside program end");
    a_busy_flag: assert property (cmd_valid && cmd_ready |-> ##1 bank_busy[op_bank_r] && kind_r != EFC_OS_IDLE)
        else $error("busy not raised on start");

    c_read: cover property (rd_valid && rd_corrected);
    c_prog: cover property (op_done && op_st_r == EFC_OS_PROG);
    c_erase: cover property (op_done && op_st_r == EFC_OS_ERASE);
    c_abort: cover property (abort_now);
endmodule

//--- verification/efc_cpu_model.sv
// Processor-side model that issues flash reads and program or erase commands
`timescale 1ns/1ps
`include "efc_consts.svh"
module efc_cpu_model
#(
    parameter int AW = 14
)
(
    input wire logic core_clk,
    output logic rd_req,
    output logic [AW-1:0] rd_addr,
    input wire logic rd_ready,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic rd_corrected,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output efc_pkg::efc_op_t cmd_op,
    output logic [AW-1:0] cmd_addr,
    output logic [`EFC_NSECT-1:0] cmd_sect_mask,
    output logic [`EFC_WL_BITS-1:0] cmd_wl_data,
    output logic erase_abort,
    input wire logic op_done,
    input wire logic op_aborted
);
    import efc_pkg::*;
    int cyc = 0;
    int take_cyc = 0;
    bit hung = 1'b0;

    initial
    begin
        rd_req = 1'b0;
        rd_addr = '0;
        cmd_valid = 1'b0;
        cmd_op = EFC_OP_PROG;
        cmd_addr = '0;
        cmd_sect_mask = '0;
        cmd_wl_data = '0;
        erase_abort = 1'b0;
    end

    always @(posedge core_clk)
        cyc <= cyc + 1;

    // Request held until an edge sees rd_ready high; released address lines show the inverted address
    task automatic read_byte(input logic [AW-1:0] a, output logic [7:0] d, output logic c,
                             output int lat);
        int k;
        int t0;
        rd_addr = a;
        rd_req = 1'b1;
        #1;
        for (k = 0; k < 50 && rd_ready !== 1'b1; k++)
        begin
            @(negedge core_clk);
            #1;
        end
        if (k == 50)
            hung = 1'b1;
        // Own start mark, so a read inside an operation leaves its timing alone
        @(negedge core_clk);
        t0 = cyc;
        rd_req = 1'b0;
        rd_addr = ~a;
        for (k = 0; k < 50 && rd_valid !== 1'b1; k++)
            @(negedge core_clk);
        if (k == 50)
            hung = 1'b1;
        lat = cyc - t0 + 1;
        d = rd_data;
        c = rd_corrected;
    endtask

    task automatic ready_for(input logic [AW-1:0] a, output logic r);
        rd_addr = a;
        #1;
        r = rd_ready;
        rd_addr = ~a;
        @(negedge core_clk);
    endtask

    // Whole 32-byte wordline per program
    task automatic command(input efc_op_t op, input logic [AW-1:0] a,
                           input logic [`EFC_NSECT-1:0] m, input logic [`EFC_WL_BITS-1:0] d);
        int k;
        cmd_op = op;
        cmd_addr = a;
        cmd_sect_mask = m;
        cmd_wl_data = d;
        cmd_valid = 1'b1;
        #1;
        for (k = 0; k < 50 && cmd_ready !== 1'b1; k++)
        begin
            @(negedge core_clk);
            #1;
        end
        @(negedge core_clk);
        take_cyc = cyc;
        if (k == 50)
            hung = 1'b1;
        cmd_valid = 1'b0;
        cmd_addr = ~a;
        cmd_sect_mask = ~m;
        cmd_wl_data = ~d;
    endtask

    // Optional abort raised in cycle abort_at of an erase
    task automatic wait_end(input int abort_at, output int n, output logic ab);
        int k;
        for (k = 0; k < 1000; k++)
        begin
            erase_abort = (cyc - take_cyc + 1 == abort_at);
            #1;
            if (op_done === 1'b1 || op_aborted === 1'b1)
                break;
            @(negedge core_clk);
        end
        if (k == 1000)
            hung = 1'b1;
        n = cyc - take_cyc + 1;
        ab = op_aborted;
        @(negedge core_clk);
        erase_abort = 1'b0;
    endtask

    task automatic idle_abort(output logic ab);
        erase_abort = 1'b1;
        #1;
        ab = op_aborted;
        @(negedge core_clk);
        erase_abort = 1'b0;
    endtask
endmodule

//--- verification/test_embedded_flash_controller.sv
// Self-checking bench for the embedded flash controller
`timescale 1ns/1ps
module test_embedded_flash_controller;
    import efc_pkg::*;
    // Short counts keep the run brief; expectations follow these values
    localparam int PROG = 20;
    localparam int ERASE = 200;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rd_req;
    logic [13:0] rd_addr;
    logic rd_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic rd_corrected;
    logic cmd_valid;
    logic cmd_ready;
    efc_op_t cmd_op;
    logic [13:0] cmd_addr;
    logic [9:0] cmd_sect_mask;
    logic [255:0] cmd_wl_data;
    logic erase_abort;
    logic [3:0] bank_busy;
    logic op_done;
    logic op_aborted;
    int error_cnt = 0;
    int tests_run = 0;

    always #25 core_clk = ~core_clk;

    efc_top #(.NB(4), .PROG_CYC(PROG), .ERASE_CYC(ERASE)) DUT (.core_clk(core_clk),
        .rst_b(rst_b), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_corrected(rd_corrected),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_sect_mask(cmd_sect_mask), .cmd_wl_data(cmd_wl_data), .erase_abort(erase_abort),
        .bank_busy(bank_busy), .op_done(op_done), .op_aborted(op_aborted));

    efc_cpu_model #(.AW(14)) cpu (.core_clk(core_clk), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_corrected(rd_corrected), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_sect_mask(cmd_sect_mask),
        .cmd_wl_data(cmd_wl_data), .erase_abort(erase_abort), .op_done(op_done),
        .op_aborted(op_aborted));

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (cpu.hung)
        begin
            error_cnt++;
            $display("unexpected %s: wait ran out", what);
            close_out();
        end
        else if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    function automatic logic [13:0] adr(input int bank, input int wl, input int b);
        return {bank[1:0], wl[6:0], b[4:0]};
    endfunction

    // Bytes lo..hi hold seed+index, the rest zero
    function automatic logic [255:0] wl_pat(input logic [7:0] seed, input int lo, input int hi);
        logic [255:0] w;
        w = '0;
        for (int b = lo; b <= hi; b++)
            w[8*b +: 8] = seed + 8'(b);
        return w;
    endfunction

    task automatic rd_chk(input logic [13:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic c;
        int lat;
        cpu.read_byte(a, d, c, lat);
        chk_val("read latency", 9, lat);
        chk_val("read byte", {24'h0, exp}, {24'h0, d});
        chk_flag("read corrected", 1'b0, c);
    endtask

    task automatic prog(input int bank, input int wl, input logic [255:0] d);
        int n;
        logic ab;
        cpu.command(EFC_OP_PROG, adr(bank, wl, 0), 10'h000, d);
        cpu.wait_end(0, n, ab);
        chk_val("program cycles", PROG, n);
    endtask

    task automatic sc_reset_state();
        chk_flag("cmd_ready", 1'b1, cmd_ready);
        chk_val("bank_busy", 32'h0, {28'h0, bank_busy});
        rd_chk(adr(2, 127, 31), 8'h00);
        rd_chk(adr(0, 0, 0), 8'h00);
    endtask

    task automatic sc_program();
        logic r;
        logic ab;
        int n;
        cpu.command(EFC_OP_PROG, adr(0, 5, 0), 10'h000, wl_pat(8'h41, 0, 31));
        chk_val("busy at program start", 32'h1, {28'h0, bank_busy});
        cpu.ready_for(adr(0, 5, 3), r);
        chk_flag("rd_ready for busy bank", 1'b0, r);
        rd_chk(adr(1, 5, 3), 8'h00);
        cpu.wait_end(0, n, ab);
        chk_val("program cycles", PROG, n);
        chk_val("busy after program", 32'h0, {28'h0, bank_busy});
        chk_flag("cmd_ready after program", 1'b1, cmd_ready);
        rd_chk(adr(0, 5, 0), 8'h41);
        rd_chk(adr(0, 5, 31), 8'h60);
        rd_chk(adr(0, 6, 0), 8'h00);
        rd_chk(adr(0, 4, 31), 8'h00);
    endtask

    // Data bank: wordline programmed twice, then two sectors erased together
    task automatic sc_data_bank();
        logic ab;
        int n;
        prog(3, 0, wl_pat(8'ha0, 0, 15));
        prog(3, 0, wl_pat(8'hc0, 16, 31));
        prog(3, 32, wl_pat(8'h11, 0, 0));
        prog(3, 64, wl_pat(8'h22, 0, 0));
        rd_chk(adr(3, 0, 15), 8'haf);
        rd_chk(adr(3, 0, 16), 8'hd0);
        rd_chk(adr(3, 32, 0), 8'h11);
        cpu.command(EFC_OP_ERASE, adr(3, 0, 0), 10'h006, '0);
        cpu.wait_end(0, n, ab);
        chk_val("erase cycles", ERASE, n);
        chk_flag("erase not aborted", 1'b0, ab);
        rd_chk(adr(3, 0, 15), 8'haf);
        rd_chk(adr(3, 32, 0), 8'h00);
        rd_chk(adr(3, 64, 0), 8'h00);
    endtask

    task automatic sc_abort();
        logic ab;
        int n;
        prog(0, 125, wl_pat(8'h55, 0, 31));
        rd_chk(adr(0, 125, 0), 8'h55);
        cpu.idle_abort(ab);
        chk_flag("abort while idle", 1'b0, ab);
        cpu.command(EFC_OP_ERASE, adr(0, 0, 0), 10'h004, '0);
        cpu.wait_end(150, n, ab);
        chk_val("abort cycle", 150, n);
        chk_flag("aborted flag", 1'b1, ab);
        chk_val("busy after abort", 32'h0, {28'h0, bank_busy});
        rd_chk(adr(0, 125, 0), 8'h00);
        rd_chk(adr(0, 5, 0), 8'h41);
    endtask

    initial
    begin
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        sc_reset_state();
        sc_program();
        sc_data_bank();
        sc_abort();
        close_out();
    end
endmodule
